//--- include/cmpdc_cfg.svh
`ifndef CMPDC_CFG_SVH
`define CMPDC_CFG_SVH
// Byte offsets of the register words
`define CMPDC_OFF_CTRL_A1   8'h00
`define CMPDC_OFF_CTRL_B1   8'h04
`define CMPDC_OFF_CTRL_A2   8'h08
`define CMPDC_OFF_CTRL_B2   8'h0C
`define CMPDC_OFF_MIRROR    8'h10
`define CMPDC_OFF_FLAGS     8'h14
// Control A fields
`define CMPDC_A_ENABLE      7
`define CMPDC_A_RESULT      6
`define CMPDC_A_PIN_EN      5
`define CMPDC_A_INVERT      4
`define CMPDC_A_SPEED       2
`define CMPDC_A_HYST        1
`define CMPDC_A_SYNC        0
`define CMPDC_A_WMASK       8'hB7
`define CMPDC_A_RESET       8'h04
// Control B fields
`define CMPDC_B_RISE        7
`define CMPDC_B_FALL        6
`define CMPDC_B_PLUS_HI     5
`define CMPDC_B_PLUS_LO     4
`define CMPDC_B_MINUS_HI    1
`define CMPDC_B_MINUS_LO    0
`define CMPDC_B_WMASK       8'hF3
`define CMPDC_B_RESET       8'h00
// Plus input codes
`define CMPDC_PLUS_OWN      2'h0
`define CMPDC_PLUS_DAC      2'h1
`define CMPDC_PLUS_FIXED    2'h2
`define CMPDC_PLUS_SHARED   2'h3
`endif

//--- include/cmpdc_pkg.sv
package cmpdc_pkg;
  typedef logic [7:0] cmpdc_byte_t;
  typedef enum logic [3:0]
  {
    CMPDC_PLUS_SEL_OWN    = 4'h1,
    CMPDC_PLUS_SEL_DAC    = 4'h2,
    CMPDC_PLUS_SEL_FIXED  = 4'h4,
    CMPDC_PLUS_SEL_SHARED = 4'h8
  } cmpdc_plus_e;
  typedef enum logic [1:0]
  {
    CMPDC_BUS_IDLE = 2'h1,
    CMPDC_BUS_DATA = 2'h2
  } cmpdc_bus_e;
endpackage

//--- include/cmpdc_chan_if.sv
`timescale 1ns/1ps
interface cmpdc_chan_if;
  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic       analog_raw;
  logic       timer_clk_raw;
  logic       result;
  logic       timer_result;
  logic       edge_hit;
  modport top  (output ctrl_a, output ctrl_b, output analog_raw, output timer_clk_raw,
                input result, input timer_result, input edge_hit);
  modport chan (input ctrl_a, input ctrl_b, input analog_raw, input timer_clk_raw,
                output result, output timer_result, output edge_hit);
endinterface

//--- design/cmpdc_channel.sv
`timescale 1ns/1ps
`include "cmpdc_cfg.svh"
module cmpdc_channel
(
  input  wire logic hclk,
  input  wire logic hresetn,
  cmpdc_chan_if.chan ch
);
  import cmpdc_pkg::*;
  logic [2:0] ana_sync;
  logic [2:0] tck_sync;
  logic       ana_stable;
  logic       tck_stable;
  logic       result;
  logic       sync_latch;
  logic       next_ana_stable;
  logic       next_tck_stable;
  logic       next_result;
  logic       next_sync_latch;
  logic       polar;
  logic       tck_fall;

  always_comb
  begin
    // Core output only counts while enabled; polarity applies regardless
    polar           = (ch.analog_raw & ch.ctrl_a[`CMPDC_A_ENABLE]) ^ ch.ctrl_a[`CMPDC_A_INVERT];
    next_ana_stable = (ana_sync[2] == ana_sync[1]) ? ana_sync[1] : ana_stable;
    next_tck_stable = (tck_sync[2] == tck_sync[1]) ? tck_sync[1] : tck_stable;
    tck_fall        = tck_stable & ~next_tck_stable;
    next_result     = (ana_stable & ch.ctrl_a[`CMPDC_A_ENABLE]) ^ ch.ctrl_a[`CMPDC_A_INVERT];
    // Prescaled timer clock is what arrives here, so sampling its fall suffices
    next_sync_latch = tck_fall ? result : sync_latch;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ana_sync   <= 3'h0;
      tck_sync   <= 3'h0;
      ana_stable <= 1'b0;
      tck_stable <= 1'b0;
      result     <= 1'b0;
      sync_latch <= 1'b0;
    end
    else
    begin
      ana_sync   <= {ana_sync[1:0], ch.analog_raw};
      tck_sync   <= {tck_sync[1:0], ch.timer_clk_raw};
      ana_stable <= next_ana_stable;
      tck_stable <= next_tck_stable;
      result     <= next_result;
      sync_latch <= next_sync_latch;
    end
  end

  assign ch.result = result;
  // Unsynchronised path stays combinational, glitches pass to the pin
  assign ch.timer_result = ch.ctrl_a[`CMPDC_A_SYNC] ? sync_latch : polar;
  // Toggling enable or invert also changes next_result and is caught here
  assign ch.edge_hit = (ch.ctrl_b[`CMPDC_B_RISE] & ~result & next_result)
                     | (ch.ctrl_b[`CMPDC_B_FALL] & result & ~next_result);
  logic unused_polar_e;
  assign unused_polar_e = ana_sync[0] & 1'b0;
endmodule

//--- design/cmpdc_top.sv
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "cmpdc_cfg.svh"
// Contract
// - Enable bit turns comparator on/off
// - Result reads 1 when plus exceeds minus
// - Pin enable overrides port data, direction gates
// - Invert bit inverts comparator output
// - Unimplemented bits ignore writes, read zero
// - Speed select resets to one
// - Hysteresis bit switches comparator hysteresis
// - Sync bit latches result on timer fall
// - Rising edge enable sets event flag
// - Falling edge enable sets event flag
// - Plus select codes own, DAC, fixed
// - Code three: shared pin or ground
// - Minus select picks one of four pins
// - Mirror holds both comparator results
// - Other bits reset to zero
// - Flag sticky; set wins over clear
// - Enable/invert toggles pass edge detection
// - Result registered per cycle; pin unregistered unless the sync bit is set
// - Sync uses prescaled timer clock
module cmpdc_top
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [7:0]         haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic [1:0]         analog_out,
  input  wire logic [1:0]         timer_clk,
  input  wire logic [1:0]         pin_direction_bit,
  input  wire logic [1:0]         port_data,
  output logic [1:0]              pin_out,
  output logic [1:0]              pin_oe,
  output logic [1:0]              timer_result,
  output logic [1:0]              comparator_on,
  output logic [1:0]              speed_select,
  output logic [1:0]              hysteresis_enable,
  output cmpdc_pkg::cmpdc_plus_e  plus_input_one,
  output cmpdc_pkg::cmpdc_plus_e  plus_input_two,
  output logic [1:0]              minus_input_one,
  output logic [1:0]              minus_input_two,
  output logic                    plus_to_ground_two,
  output logic [1:0]              comparator_event_flag
);
  import cmpdc_pkg::*;

  cmpdc_byte_t ctrl_a [2];
  cmpdc_byte_t ctrl_b [2];
  cmpdc_byte_t next_ctrl_a [2];
  cmpdc_byte_t next_ctrl_b [2];
  logic [1:0]  flag;
  logic [1:0]  next_flag;
  logic [1:0]  result;
  logic [1:0]  edge_hit;
  logic [1:0]  tres;
  logic [7:0]  wr_addr;
  logic        wr_pend;
  logic [7:0]  next_wr_addr;
  logic        next_wr_pend;
  logic [31:0] next_hrdata;
  cmpdc_bus_e  bus_state;
  cmpdc_bus_e  next_bus_state;
  logic        take;
  cmpdc_byte_t rd_byte;

  function automatic cmpdc_plus_e plus_decode(input logic [1:0] code);
    cmpdc_plus_e sel;
    case (code)
      `CMPDC_PLUS_OWN:    sel = CMPDC_PLUS_SEL_OWN;
      `CMPDC_PLUS_DAC:    sel = CMPDC_PLUS_SEL_DAC;
      `CMPDC_PLUS_FIXED:  sel = CMPDC_PLUS_SEL_FIXED;
      default:            sel = CMPDC_PLUS_SEL_SHARED;
    endcase
    return sel;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_chan
      cmpdc_chan_if cif ();
      assign cif.ctrl_a        = ctrl_a[gi];
      assign cif.ctrl_b        = ctrl_b[gi];
      assign cif.analog_raw    = analog_out[gi];
      assign cif.timer_clk_raw = timer_clk[gi];
      assign result[gi]        = cif.result;
      assign tres[gi]          = cif.timer_result;
      assign edge_hit[gi]      = cif.edge_hit;
      cmpdc_channel u_chan
      (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ch      (cif.chan)
      );
      // Override is independent of the enable bit
      assign pin_out[gi]           = ctrl_a[gi][`CMPDC_A_PIN_EN] ? tres[gi] : port_data[gi];
      assign pin_oe[gi]            = ~pin_direction_bit[gi];
      assign timer_result[gi]      = tres[gi];
      assign comparator_on[gi]     = ctrl_a[gi][`CMPDC_A_ENABLE];
      assign speed_select[gi]      = ctrl_a[gi][`CMPDC_A_SPEED];
      assign hysteresis_enable[gi] = ctrl_a[gi][`CMPDC_A_HYST];
    end
  endgenerate

  assign plus_input_one  = plus_decode(ctrl_b[0][`CMPDC_B_PLUS_HI:`CMPDC_B_PLUS_LO]);
  assign plus_input_two  = plus_decode(ctrl_b[1][`CMPDC_B_PLUS_HI:`CMPDC_B_PLUS_LO]);
  // Second channel's code three means ground rather than the shared pin
  assign plus_to_ground_two = (plus_input_two == CMPDC_PLUS_SEL_SHARED);
  assign minus_input_one = ctrl_b[0][`CMPDC_B_MINUS_HI:`CMPDC_B_MINUS_LO];
  assign minus_input_two = ctrl_b[1][`CMPDC_B_MINUS_HI:`CMPDC_B_MINUS_LO];
  assign comparator_event_flag = flag;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign take      = hsel & hready & htrans[1];

  always_comb
  begin
    rd_byte = 8'h00;
    case (haddr)
      // Result bit always comes from hardware, never from storage
      `CMPDC_OFF_CTRL_A1: rd_byte = (ctrl_a[0] & `CMPDC_A_WMASK) | {1'b0, result[0], 6'h00};
      `CMPDC_OFF_CTRL_B1: rd_byte = ctrl_b[0] & `CMPDC_B_WMASK;
      `CMPDC_OFF_CTRL_A2: rd_byte = (ctrl_a[1] & `CMPDC_A_WMASK) | {1'b0, result[1], 6'h00};
      `CMPDC_OFF_CTRL_B2: rd_byte = ctrl_b[1] & `CMPDC_B_WMASK;
      `CMPDC_OFF_MIRROR:  rd_byte = {6'h00, result[1], result[0]};
      `CMPDC_OFF_FLAGS:   rd_byte = {6'h00, flag};
      default:            rd_byte = 8'h00;
    endcase
  end

  always_comb
  begin
    next_bus_state = bus_state;
    next_wr_pend   = 1'b0;
    next_wr_addr   = wr_addr;
    next_hrdata    = hrdata;
    next_ctrl_a    = ctrl_a;
    next_ctrl_b    = ctrl_b;
    // Set wins: an edge in the clearing cycle keeps the flag
    next_flag      = flag;
    if (wr_pend && wr_addr == `CMPDC_OFF_FLAGS)
    begin
      next_flag = flag & ~hwdata[1:0];
    end
    next_flag = next_flag | edge_hit;
    if (wr_pend)
    begin
      case (wr_addr)
        `CMPDC_OFF_CTRL_A1: next_ctrl_a[0] = hwdata[7:0] & `CMPDC_A_WMASK;
        `CMPDC_OFF_CTRL_B1: next_ctrl_b[0] = hwdata[7:0] & `CMPDC_B_WMASK;
        `CMPDC_OFF_CTRL_A2: next_ctrl_a[1] = hwdata[7:0] & `CMPDC_A_WMASK;
        `CMPDC_OFF_CTRL_B2: next_ctrl_b[1] = hwdata[7:0] & `CMPDC_B_WMASK;
        default:            next_ctrl_b[0] = next_ctrl_b[0];
      endcase
    end
    case (bus_state)
      CMPDC_BUS_IDLE:
      begin
        if (take)
        begin
          next_bus_state = CMPDC_BUS_DATA;
          next_wr_pend   = hwrite;
          next_wr_addr   = haddr;
          next_hrdata    = hwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end
      end
      CMPDC_BUS_DATA:
      begin
        next_bus_state = CMPDC_BUS_IDLE;
        if (take)
        begin
          next_bus_state = CMPDC_BUS_DATA;
          next_wr_pend   = hwrite;
          next_wr_addr   = haddr;
          next_hrdata    = hwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end
      end
      default:
        next_bus_state = CMPDC_BUS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_a[0] <= `CMPDC_A_RESET;
      ctrl_a[1] <= `CMPDC_A_RESET;
      ctrl_b[0] <= `CMPDC_B_RESET;
      ctrl_b[1] <= `CMPDC_B_RESET;
      flag      <= 2'h0;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      bus_state <= CMPDC_BUS_IDLE;
    end
    else
    begin
      ctrl_a    <= next_ctrl_a;
      ctrl_b    <= next_ctrl_b;
      flag      <= next_flag;
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      hrdata    <= next_hrdata;
      bus_state <= next_bus_state;
    end
  end

  logic unused_bits;
  assign unused_bits = ^{hsize, hwdata[31:8]};
endmodule

//--- dv/cmpdc_top_sva.sv
`timescale 1ns/1ps
module cmpdc_top_sva
(
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic                   hsel,
  input wire logic [7:0]             haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [31:0]            hwdata,
  input wire logic                   hready,
  input wire logic [31:0]            hrdata,
  input wire logic [1:0]             pin_direction_bit,
  input wire logic [1:0]             pin_oe,
  input wire logic [1:0]             comparator_on,
  input wire logic [1:0]             speed_select,
  input wire logic [1:0]             hysteresis_enable,
  input wire cmpdc_pkg::cmpdc_plus_e plus_input_one,
  input wire cmpdc_pkg::cmpdc_plus_e plus_input_two,
  input wire logic [1:0]             minus_input_two,
  input wire logic                   plus_to_ground_two,
  input wire logic [1:0]             comparator_event_flag
);
  import cmpdc_pkg::*;
  logic       wr_q;
  logic       rd_q;
  logic [7:0] addr_q;
  logic [1:0] clr_m;
  // Data phase tracking, advanced only when the bus moves
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= 8'h00;
    end
    else if (hready)
    begin
      wr_q   <= hsel && htrans[1] && hwrite;
      rd_q   <= hsel && htrans[1] && !hwrite;
      addr_q <= haddr;
    end
  end
  assign clr_m = (wr_q && addr_q == 8'h14) ? hwdata[1:0] : 2'h0;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_wr_a1; wr_q && addr_q == 8'h00; endsequence
  sequence s_wr_b2; wr_q && addr_q == 8'h0C; endsequence
  property p_oe; pin_oe == ~pin_direction_bit; endproperty
  property p_rdhi; rd_q |-> hrdata[31:8] == 24'h000000; endproperty
  property p_unm; rd_q && addr_q > 8'h14 |-> hrdata == 32'h00000000; endproperty
  property p_rst; !$past(hresetn) |-> speed_select == 2'h3 && comparator_on == 2'h0 && !comparator_event_flag;
  endproperty
  property p_a1; s_wr_a1 |=> comparator_on[0] == $past(hwdata[7]) && speed_select[0] == $past(hwdata[2])
    && hysteresis_enable[0] == $past(hwdata[1]); endproperty
  property p_b2; s_wr_b2 |=> plus_to_ground_two == ($past(hwdata[5:4]) == 2'h3)
    && minus_input_two == $past(hwdata[1:0]); endproperty
  property p_sticky; ##1 (~comparator_event_flag & $past(comparator_event_flag) & ~$past(clr_m)) == 2'h0;
  endproperty
  property p_onehot; $onehot(plus_input_one) && $onehot(plus_input_two); endproperty
  a_oe: assert property (p_oe) else $error("pin enable differs from direction");
  a_rdhi: assert property (p_rdhi) else $error("upper read bits not zero");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  a_rst: assert property (p_rst) else $error("reset values wrong");
  a_a1: assert property (p_a1) else $error("control a fields not applied");
  a_b2: assert property (p_b2) else $error("control b two not applied");
  a_sticky: assert property (p_sticky) else $error("event flag lost without clear");
  a_onehot: assert property (p_onehot) else $error("plus select not one-hot");
endmodule
bind cmpdc_top cmpdc_top_sva sva_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .pin_direction_bit(pin_direction_bit), .pin_oe(pin_oe), .comparator_on(comparator_on),
  .speed_select(speed_select), .hysteresis_enable(hysteresis_enable), .plus_input_one(plus_input_one),
  .plus_input_two(plus_input_two), .minus_input_two(minus_input_two), .plus_to_ground_two(plus_to_ground_two),
  .comparator_event_flag(comparator_event_flag));

//--- dv/cmpdc_analog_model.sv
`timescale 1ns/1ps
module cmpdc_analog_model
(
  input  wire logic hclk,
  output logic [1:0] analog_out,
  output logic [1:0] timer_clk
);
  initial
  begin
    analog_out = 2'h0;
    timer_clk  = 2'h0;
  end
  // Cores are asynchronous; edges here only keep the run repeatable
  task automatic set_level(input int ch, input logic v);
    @(posedge hclk);
    analog_out[ch] <= v;
  endtask
  // Prescaled timer clock, idle low between pulses
  task automatic timer_pulse(input int ch);
    @(posedge hclk);
    timer_clk[ch] <= 1'b1;
    repeat (6) @(posedge hclk);
    timer_clk[ch] <= 1'b0;
  endtask
endmodule

//--- dv/test_comparator_digital_control.sv
`timescale 1ns/1ps
module test_comparator_digital_control;
  import cmpdc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hready, hreadyout, hresp, plus_to_ground_two;
  logic [7:0] haddr;
  logic [1:0] htrans, analog_out, timer_clk, pin_direction_bit, port_data, pin_out, pin_oe, timer_result;
  logic [1:0] comparator_on, speed_select, hysteresis_enable, minus_input_one, minus_input_two, comparator_event_flag;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rdata;
  cmpdc_plus_e plus_input_one, plus_input_two;
  int errors = 0;
  int n_tests = 0;
  always #25 hclk = ~hclk;
  assign hready = hreadyout;
  cmpdc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .analog_out(analog_out), .timer_clk(timer_clk), .pin_direction_bit(pin_direction_bit), .port_data(port_data),
    .pin_out(pin_out), .pin_oe(pin_oe), .timer_result(timer_result), .comparator_on(comparator_on),
    .speed_select(speed_select), .hysteresis_enable(hysteresis_enable), .plus_input_one(plus_input_one),
    .plus_input_two(plus_input_two), .minus_input_one(minus_input_one), .minus_input_two(minus_input_two),
    .plus_to_ground_two(plus_to_ground_two), .comparator_event_flag(comparator_event_flag));
  cmpdc_analog_model model_u (.hclk(hclk), .analog_out(analog_out), .timer_clk(timer_clk));
  task automatic report_and_stop();
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] e);
    n_tests++;
    if (got !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); bus(a, 1'b1, d); endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(nm, rdata, e);
  endtask
  task automatic wt(input int n); repeat (n) @(posedge hclk); endtask
  task automatic t_reset();
    for (int i = 0; i < 6; i++)
      rdc("reset value", 8'(i * 4), (i < 4 && i % 2 == 0) ? 32'h04 : 32'h00);
  endtask
  task automatic t_masks();
    wr(8'h04, 32'hFF); wr(8'h00, 32'hFF); wt(10);
    rdc("ctrl a1", 8'h00, 32'hF7);
    rdc("ctrl b1", 8'h04, 32'hF3);
    rdc("mirror", 8'h10, 32'h01);
    chk("a1 ports", {comparator_on[0], speed_select[0], hysteresis_enable[0]}, 32'h7);
    wr(8'h20, 32'hFF);
    rdc("unmapped", 8'h20, 32'h0);
    rdc("rise flag", 8'h14, 32'h01);
    wr(8'h14, 32'h01);
    rdc("flag clear", 8'h14, 32'h0);
    wr(8'h00, 32'h40); wt(10);
    rdc("ctrl a1 off", 8'h00, 32'h00);
    rdc("toggle flag", 8'h14, 32'h01);
    wr(8'h14, 32'h01);
  endtask
  task automatic t_edge();
    wr(8'h08, 32'h80); wr(8'h0C, 32'h80);
    model_u.set_level(1, 1'b1); wt(10);
    rdc("ch2 rise", 8'h14, 32'h02);
    rdc("mirror two", 8'h10, 32'h02);
    wr(8'h14, 32'h02);
    model_u.set_level(1, 1'b0); wt(10);
    rdc("fall masked", 8'h14, 32'h00);
  endtask
  task automatic t_pin();
    wr(8'h00, 32'hA0);
    model_u.set_level(0, 1'b1); wt(10);
    chk("pin result", pin_out[0], 32'h1);
    chk("pin oe", pin_oe, 32'h1);
    wr(8'h00, 32'h80); wt(2);
    chk("pin port", pin_out[0], 32'h0);
    chk("pin port two", pin_out[1], 32'h1);
  endtask
  task automatic t_sync();
    chk("async timer", timer_result[0], 32'h1);
    wr(8'h00, 32'h81);
    // Latch leaves reset at zero, so one timer fall must load the high result first
    model_u.timer_pulse(0); wt(10);
    chk("sync load", timer_result[0], 32'h1);
    model_u.set_level(0, 1'b0); wt(10);
    chk("sync hold", timer_result[0], 32'h1);
    model_u.timer_pulse(0); wt(10);
    chk("sync update", timer_result[0], 32'h0);
  endtask
  task automatic t_sel();
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h04, 32'(c * 17)); wr(8'h0C, 32'(c * 17)); wt(2);
      chk("plus one", plus_input_one, 32'h1 << c);
      chk("minus one", minus_input_one, 32'(c));
      chk("ground two", plus_to_ground_two, 32'(c == 3));
      chk("plus two", plus_input_two, 32'h1 << c);
      chk("minus two", minus_input_two, 32'(c));
    end
  endtask
  // Reset in mid-run must bring every register back, not only at power-up
  task automatic t_reset2();
    wr(8'h00, 32'hB7); wr(8'h0C, 32'hF3);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
  endtask
  initial
  begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    pin_direction_bit = 2'h2; port_data = 2'h2;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset(); t_masks(); t_edge(); t_pin(); t_sync(); t_sel(); t_reset2();
    report_and_stop();
  end
  // Whole run is a few hundred cycles; a hang runs on until this limit of 20000 cycles
  initial
  begin
    repeat (20000) @(posedge hclk);
    errors++;
    report_and_stop();
  end
endmodule
